// [verilog/iad_decoder.v]
// Indirect data port address decoder
`timescale 1ns/100ps
`default_nettype none
`include "iad_defs.vh"
// Behaviour
// - An access to the indirect data port goes to the address held in its pointer pair.
// - A pointer naming either indirect port reads zero and suppresses the write.
// - The pointer is the high byte above the low byte, a 16-bit address.
// - Pointer 0x000 to 0xFFF maps straight onto banked data memory addresses.
// - Pointer 0x2000 to 0x29AF is a linear view of the 80-byte RAM blocks of banks 0 to 30.
// - Stepping past one bank's last RAM byte lands on the next bank's first.
// - Unimplemented locations in the linear region read as 0x00.
// - The 16 common bytes never appear in the linear region.
// - With the pointer top bit set, the low 15 bits address program flash.
// - A flash read returns only the low eight bits of the word.
// - Writes to the flash region have no effect.
// - A flash read takes one extra instruction cycle.
module iad_decoder (
  input wire clk_in,
  input wire reset_in,
  input wire port_sel_in,
  input wire [7:0] pointer0_high_byte_in,
  input wire [7:0] pointer0_low_byte_in,
  input wire [7:0] pointer1_high_byte_in,
  input wire [7:0] pointer1_low_byte_in,
  input wire access_in,
  input wire write_in,
  input wire [7:0] wdata_in,
  input wire [7:0] mem_rdata_in,
  input wire [13:0] flash_rdata_in,
  output reg [11:0] mem_addr_out,
  output reg mem_we_out,
  output reg [7:0] mem_wdata_out,
  output reg [14:0] flash_addr_out,
  output reg flash_re_out,
  output reg [7:0] rdata_out,
  output reg rdata_valid_out,
  output wire stall_out
);

  // ***************
  // Pointer select
  // ***************
  wire [15:0] ptr0;
  wire [15:0] ptr1;
  wire [15:0] ptr;

  assign ptr0 = {pointer0_high_byte_in, pointer0_low_byte_in};
  assign ptr1 = {pointer1_high_byte_in, pointer1_low_byte_in};
  assign ptr = port_sel_in ? ptr1 : ptr0;

  // ***************
  // Region decode
  // ***************
  wire is_flash;
  wire is_trad;
  wire is_lin;
  wire is_mapped;
  wire is_port0;
  wire is_port1;
  wire is_self;

  assign is_flash = ptr[`IAD_FLASH_BIT];
  assign is_trad = (ptr <= `IAD_TRAD_LAST);
  assign is_lin = (ptr >= `IAD_LIN_BASE) && (ptr <= `IAD_LIN_LAST);
  assign is_mapped = is_trad || is_lin;

  // Ports sit at the same offset in every bank
  assign is_port0 = (ptr[6:0] == `IAD_PORT0_ADDR);
  assign is_port1 = (ptr[6:0] == `IAD_PORT1_ADDR);
  assign is_self = is_trad && (is_port0 || is_port1);

  // ***************
  // Linear region
  // ***************
  wire [15:0] lin_off;
  wire [11:0] lin_addr;

  assign lin_off = ptr - `IAD_LIN_BASE;

  iad_linear_map u_map (
    .offset_in(lin_off[11:0]),
    .banked_addr_out(lin_addr)
  );

  // ***************
  // Request qualifiers
  // ***************
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_FLASH = 2'b01;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [1:0] wait_cnt_r;
  reg [1:0] wait_cnt_nxt;
  reg [7:0] rdata_nxt;
  reg rdata_valid_nxt;
  reg [7:0] data_rd_val;
  wire [7:0] flash_byte;
  wire busy;
  wire rd_req;
  wire wr_req;
  wire flash_rd;
  wire data_rd;

  assign busy = (state_r != ST_IDLE);
  assign rd_req = access_in && !write_in;
  assign wr_req = access_in && write_in;
  // Read requests during a flash wait are ignored
  assign flash_rd = rd_req && is_flash && !busy;
  assign data_rd = rd_req && !is_flash && !busy;
  assign stall_out = flash_rd;

  // ***************
  // Address drive
  // ***************
  always @* begin
    mem_addr_out = 12'h000;
    flash_addr_out = ptr[14:0];
    if (is_trad) begin
      mem_addr_out = ptr[11:0];
    end else if (is_lin) begin
      mem_addr_out = lin_addr;
    end
  end

  always @* begin
    flash_re_out = flash_rd;
  end

  // ***************
  // Write path
  // ***************
  always @* begin
    mem_wdata_out = wdata_in;
    mem_we_out = 1'b0;
    // Flash writes and self references never reach memory
    if (wr_req && is_mapped && !is_self && !is_flash) begin
      mem_we_out = 1'b1;
    end
  end

  // ***************
  // Read data select
  // ***************
  always @* begin
    data_rd_val = 8'h00;
    if (is_mapped && !is_self) begin
      data_rd_val = mem_rdata_in;
    end
  end

  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_flash_byte
      assign flash_byte[b] = flash_rdata_in[b];
    end
  endgenerate

  // ***************
  // Access sequencer
  // ***************
  always @* begin
    state_nxt = state_r;
    wait_cnt_nxt = wait_cnt_r;
    rdata_nxt = rdata_out;
    rdata_valid_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (flash_rd) begin
          state_nxt = ST_FLASH;
          wait_cnt_nxt = 2'h1;
        end else if (data_rd) begin
          rdata_valid_nxt = 1'b1;
          rdata_nxt = data_rd_val;
        end
      end
      ST_FLASH: begin
        if (wait_cnt_r == `IAD_EXTRA_CYC) begin
          state_nxt = ST_IDLE;
          wait_cnt_nxt = 2'h0;
          rdata_nxt = flash_byte;
          rdata_valid_nxt = 1'b1;
        end else begin
          wait_cnt_nxt = wait_cnt_r + 2'h1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        wait_cnt_nxt = 2'h0;
      end
    endcase
  end

  // ***************
  // State registers
  // ***************
  always @(posedge clk_in) begin
    if (reset_in) begin
      state_r <= ST_IDLE;
      wait_cnt_r <= 2'h0;
      rdata_out <= 8'h00;
      rdata_valid_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wait_cnt_r <= wait_cnt_nxt;
      rdata_out <= rdata_nxt;
      rdata_valid_out <= rdata_valid_nxt;
    end
  end

endmodule
`default_nettype wire

// [pkg/iad_defs.vh]
// Constants for the indirect address decoder
`ifndef IAD_DEFS_VH
`define IAD_DEFS_VH
`define IAD_TRAD_LAST 16'h0FFF
`define IAD_LIN_BASE 16'h2000
`define IAD_LIN_LAST 16'h29AF
`define IAD_GPR_BYTES 7'h50
`define IAD_GPR_START 7'h20
`define IAD_PORT0_ADDR 7'h00
`define IAD_PORT1_ADDR 7'h01
`define IAD_FLASH_BIT 15
`define IAD_BANK_W 5
`define IAD_EXTRA_CYC 2'h1
`endif

// [verilog/iad_linear_map.v]
// Linear region offset to banked address conversion
`timescale 1ns/100ps
`default_nettype none
`include "iad_defs.vh"
module iad_linear_map (
  input wire [11:0] offset_in,
  output reg [11:0] banked_addr_out
);
  reg [4:0] bank;
  reg [11:0] rem;
  integer i;
  // ***************
  // Divide by the 80 RAM bytes per bank
  // ***************
  always @* begin
    bank = 5'h0;
    rem = offset_in;
    for (i = 0; i < 31; i = i + 1) begin
      if (rem >= {5'h0, `IAD_GPR_BYTES}) begin
        rem = rem - {5'h0, `IAD_GPR_BYTES};
        bank = bank + 5'h1;
      end
    end
    banked_addr_out = {bank, rem[6:0] + `IAD_GPR_START};
  end
endmodule
`default_nettype wire

// [test/iad_props.sv]
// Checker for the indirect address decoder
`timescale 1ns/100ps
`default_nettype none
module iad_props(
  input wire clk_in,
  input wire reset_in,
  input wire access_in,
  input wire write_in,
  input wire port_sel_in,
  input wire mem_we_out,
  input wire stall_out,
  input wire flash_re_out,
  input wire rdata_valid_out,
  input wire [7:0] pointer0_high_byte_in,
  input wire [7:0] pointer0_low_byte_in,
  input wire [7:0] pointer1_high_byte_in,
  input wire [7:0] pointer1_low_byte_in,
  input wire [7:0] rdata_out,
  input wire [14:0] flash_addr_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire [15:0] p=port_sel_in?{pointer1_high_byte_in,pointer1_low_byte_in}:
    {pointer0_high_byte_in,pointer0_low_byte_in};
  wire rd=access_in&&!write_in;
  wire wr=access_in&&write_in;
  sequence s_late; !rdata_valid_out ##1 rdata_valid_out; endsequence
  property p_fl; rd&&p[15] |=> s_late; endproperty
  a_fl: assert property(p_fl) else $error("flash read answer late");
  property p_st; rd&&p[15] |-> stall_out&&flash_re_out; endproperty
  a_st: assert property(p_st) else $error("flash read without stall");
  property p_dm; rd&&!p[15] |=> rdata_valid_out; endproperty
  a_dm: assert property(p_dm) else $error("data read answer late");
  property p_fw; access_in&&p[15] |-> !mem_we_out; endproperty
  a_fw: assert property(p_fw) else $error("flash write reached memory");
  property p_fa; access_in&&p[15] |-> flash_addr_out==p[14:0]; endproperty
  a_fa: assert property(p_fa) else $error("flash address wrong");
  property p_sr; access_in&&p<16'h1000&&p[6:1]==6'h00 |-> !mem_we_out; endproperty
  a_sr: assert property(p_sr) else $error("port write not suppressed");
  property p_wr; wr&&p<16'h1000&&p[6:1]!=6'h00 |-> mem_we_out; endproperty
  a_wr: assert property(p_wr) else $error("banked write lost");
  property p_ln; rd&&p[15:12]==4'h1 |=> rdata_out==8'h00; endproperty
  a_ln: assert property(p_ln) else $error("unmapped read not zero");
endmodule
bind iad_decoder iad_props iad_props_inst(.*);
`default_nettype wire

// [test/iad_mem_model.sv]
// Data and program memory model
`timescale 1ns/100ps
`default_nettype none
module iad_mem_model(input wire clk_in,mem_we_in,input wire [11:0] addr_in,
  input wire [7:0] wdata_in,input wire [14:0] faddr_in,output wire [7:0] rdata_out,
  output wire [13:0] frdata_out);
  logic [7:0] m[4096];
  initial foreach(m[i]) m[i]=8'h00;
  always @(posedge clk_in) if(mem_we_in) m[addr_in]<=wdata_in;
  assign rdata_out=m[addr_in];
  assign frdata_out=faddr_in[13:0]^14'h2a5b;
endmodule
`default_nettype wire

// [test/indirect_address_decoder_test.sv]
// Self-checking bench for the indirect address decoder
`timescale 1ns/100ps
`default_nettype none
module indirect_address_decoder_test;
  logic clk_in=0,reset_in=1,port_sel_in=0,access_in=0,write_in=0,we,vld;
  logic [7:0] h0=0,l0=0,h1=0,l1=0,wdata_in=0,md,rd,wd;
  logic [13:0] fd; logic [11:0] ma; logic [14:0] fa; logic [15:0] r=16'h0025,p;
  int miscompares=0,num_checks=0,m[4096];
  initial forever #4 clk_in=~clk_in;
  iad_decoder iad_decoder_inst(.clk_in,.reset_in,.port_sel_in,.pointer0_high_byte_in(h0),
    .pointer0_low_byte_in(l0),.pointer1_high_byte_in(h1),.pointer1_low_byte_in(l1),.access_in,
    .write_in,.wdata_in,.mem_rdata_in(md),.flash_rdata_in(fd),.mem_addr_out(ma),.mem_we_out(we),
    .mem_wdata_out(wd),.flash_addr_out(fa),.flash_re_out(),.rdata_out(rd),.rdata_valid_out(vld),
    .stall_out());
  iad_mem_model iad_mem_model_inst(.clk_in,.mem_we_in(we),.addr_in(ma),.wdata_in(wd),
    .faddr_in(fa),.rdata_out(md),.frdata_out(fd));
  function logic [15:0] lf(logic [15:0] x); return {x[14:0],x[15]^x[13]^x[12]^x[10]}; endfunction
  function int ad(logic [15:0] q);
    if(q<16'h1000) return q[6:1]==0?-1:q;
    if(q>=16'h2000&&q<=16'h29af) return (q-16'h2000)/80*128+32+(q-16'h2000)%80;
    return -1;
  endfunction
  task test_done;
    $display("checks %0d miscompares %0d",num_checks,miscompares);
    if(miscompares==0&&num_checks>0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task go(logic [15:0] q,logic w); int e,a,k;
    a=ad(q);
    e=q[15]?(q[7:0]^8'h5b):(a<0?0:m[a]);
    @(posedge clk_in); {h0,l0,h1,l1}<=r[8]?{~q,q}:{q,~q}; port_sel_in<=r[8];
    access_in<=1; write_in<=w; wdata_in<=r[7:0];
    @(posedge clk_in); access_in<=0;
    if(w) begin if(!q[15]&&a>=0) m[a]=r[7:0]; end
    else begin k=0;
      #1;
      while(vld!==1'b1&&k<4) begin @(posedge clk_in); #1; k++; end
      if(vld!==1'b1) begin
        miscompares++;
        $display("BAD rdata_valid_out exp 1 got %b",vld);
        test_done;
      end
      num_checks++;
      if(rd!==e[7:0]) begin miscompares++; $display("BAD rdata_out exp %h got %h",e[7:0],rd); end
    end
  endtask
  initial begin repeat(2) @(posedge clk_in); reset_in<=0;
    for(int i=0;i<400;i++) begin r=lf(r);
      case(r[1:0]) 0: p={4'h0,r[15:4]};
        1: p=16'h2000+r[15:4]%2480;
        2: p={1'b1,r[15:1]};
        default: p=r[3]?{4'h0,r[15:11],6'h00,r[4]}:r;
      endcase
      go(p,1);
      go(p,0);
    end
    test_done;
  end
endmodule
`default_nettype wire
